// ---- pkg/clocked_io_port_pkg.sv ----
package clocked_io_port_pkg;

   localparam int NUM_PORTS   = 5;
   localparam int NUM_PINS    = 32;
   localparam int NUM_CLKBLK  = 6;
   localparam int COUNT_WIDTH = 16;
   localparam int ADDR_WIDTH  = 12;
   localparam int DIV_WIDTH   = 8;

   // port widths, narrowest first; port k drives pins [width-1:0]
   localparam logic [NUM_PORTS-1:0][5:0] PORT_WIDTH = {6'h20, 6'h10, 6'h08, 6'h04, 6'h01};

   // timing
   localparam int CLK_HZ  = 200_000_000;
   localparam int REF_HZ  = 100_000_000;
   localparam int REF_DIV = CLK_HZ / REF_HZ;

   // register map
   localparam logic [ADDR_WIDTH-1:0] PORT_END    = 12'h0A0;
   localparam logic [4:0]            REG_CTRL    = 5'h00;
   localparam logic [4:0]            REG_DATA    = 5'h04;
   localparam logic [4:0]            REG_COUNT   = 5'h08;
   localparam logic [4:0]            REG_STAMP   = 5'h0C;
   localparam logic [4:0]            REG_TIME    = 5'h10;
   localparam logic [4:0]            REG_COND    = 5'h14;
   localparam logic [4:0]            REG_STATUS  = 5'h18;
   localparam logic [ADDR_WIDTH-1:0] CLKBLK_BASE = 12'h100;
   localparam logic [ADDR_WIDTH-1:0] LINK_CTRL   = 12'h120;

   // control fields
   localparam int CTRL_EN      = 0;
   localparam int CTRL_DIR_OUT = 1;
   localparam int CTRL_OC      = 2;
   localparam int CTRL_STRB    = 3;
   localparam int CTRL_BLK_LSB = 4;
   localparam int TIME_EN      = 16;
   localparam int CLK_SRC_PIN  = 0;
   localparam int CLK_DIV_LSB  = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [NUM_PINS-1:0] port_mask(input logic [5:0] w);
      port_mask = {NUM_PINS{1'b1}} >> (6'h20 - w);
   endfunction : port_mask

endpackage : clocked_io_port_pkg

// ---- rtl/clocked_io_port_unit.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: ports of 1, 4, 8, 16 and 32 bits join the tile to the pins.
// RULE_02: each port is wholly input or wholly output.
// RULE_03: ports drive pins or sample them, optionally waiting on a pin condition.
// RULE_04: every register access answers in one cycle.
// RULE_05: open-collector port pulls low for zero, floats for one, whole port.
// RULE_06: data passes through a shift register plus transfer register per port.
// RULE_07: each port has a 16-bit counter scheduling pin transfers.
// RULE_08: counter always readable; transfer may wait for a chosen count.
// RULE_09: each transfer captures the counter as a timestamp.
// RULE_10: an enabled link disables every port on its pins.
// RULE_11: narrower enabled port wins shared pins; unshared wider pins stay usable.
// RULE_12: a port always works at its full width.
// RULE_13: six clock blocks; block 0 is the 100 MHz reference.
// RULE_14: a clock block may take its clock from the 1-bit port pin.
// RULE_15: a clock block may divide its pin clock.
// RULE_16: ports honour incoming strobes and emit outgoing strobes with data.
// RULE_17: after reset every port uses clock block 0.
// RULE_18: pin events go to the tile as event pulses, not interrupts.
// RULE_19: port counter steps once per clock block tick and wraps.
// RULE_20: deferred transfer happens at first tick with count equal; pending cleared.
module clocked_io_port_unit
   import clocked_io_port_pkg::*;
#(
   parameter logic [NUM_PINS-1:0] LINK_PIN_MASK = 32'h000000FF
)(
   input  wire  logic                    aclk,
   input  wire  logic                    aresetn,
   input  wire  logic [ADDR_WIDTH-1:0]   awaddr,
   input  wire  logic                    awvalid,
   output logic                          awready,
   input  wire  logic [31:0]             wdata,
   input  wire  logic [3:0]              wstrb,
   input  wire  logic                    wvalid,
   output logic                          wready,
   output logic [1:0]                    bresp,
   output logic                          bvalid,
   input  wire  logic                    bready,
   input  wire  logic [ADDR_WIDTH-1:0]   araddr,
   input  wire  logic                    arvalid,
   output logic                          arready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   output logic                          rvalid,
   input  wire  logic                    rready,
   input  wire  logic [NUM_PINS-1:0]     pin_in,
   output logic [NUM_PINS-1:0]           pin_out,
   output logic [NUM_PINS-1:0]           pin_oe,
   input  wire  logic [NUM_PORTS-1:0]    incoming_strobe,
   output logic [NUM_PORTS-1:0]          outgoing_strobe,
   output logic [NUM_PORTS-1:0]          port_event
);

   typedef struct packed {
      logic                                  bvalid;
      logic [1:0]                            bresp;
      logic                                  rvalid;
      logic [31:0]                           rdata;
      logic [1:0]                            rresp;
      logic [3:0]                            ref_cnt;
      logic [NUM_CLKBLK-1:0]                 blk_src_pin;
      logic [NUM_CLKBLK-1:0][DIV_WIDTH-1:0]  blk_div;
      logic [NUM_CLKBLK-1:0][DIV_WIDTH-1:0]  blk_cnt;
      logic                                  pin0_prev;
      logic                                  link_en;
      logic [NUM_PORTS-1:0]                  en;
      logic [NUM_PORTS-1:0]                  dir_out;
      logic [NUM_PORTS-1:0]                  oc;
      logic [NUM_PORTS-1:0]                  strb_en;
      logic [NUM_PORTS-1:0][2:0]             blk_sel;
      logic [NUM_PORTS-1:0][COUNT_WIDTH-1:0] count;
      logic [NUM_PORTS-1:0][COUNT_WIDTH-1:0] stamp;
      logic [NUM_PORTS-1:0][COUNT_WIDTH-1:0] time_val;
      logic [NUM_PORTS-1:0]                  time_pend;
      logic [NUM_PORTS-1:0][31:0]            cond_val;
      logic [NUM_PORTS-1:0]                  cond_pend;
      logic [NUM_PORTS-1:0][31:0]            xfer;
      logic [NUM_PORTS-1:0]                  xfer_full;
      logic [NUM_PORTS-1:0][31:0]            shift;
      logic [NUM_PORTS-1:0][5:0]             shift_cnt;
      logic [NUM_PORTS-1:0]                  strobe_out;
      logic [NUM_PORTS-1:0]                  event_out;
      logic [NUM_PINS-1:0]                   pin_out;
      logic [NUM_PINS-1:0]                   pin_oe;
   } state_type;

   state_type             s;
   state_type             next_s;
   logic                  wr_go;
   logic                  rd_go;
   logic                  ref_tick;
   logic                  pin_edge;
   logic                  src_tick;
   logic [NUM_CLKBLK-1:0] blk_tick;
   logic [NUM_PORTS-1:0]  port_tick;
   logic [NUM_PORTS-1:0]  live;
   logic [NUM_PORTS-1:0]  hw_set;
   logic [NUM_PINS-1:0]   mask;
   logic [5:0]            w;
   logic [5:0]            chunks;
   logic                  time_ok;
   logic [31:0]           in_shift;
   logic [31:0]           wmask;
   logic [31:0]           img;
   logic [2:0]            owner;
   logic                  owned;
   logic [2:0]            wp;
   logic [2:0]            rp;
   logic [2:0]            wb;
   logic [2:0]            rb;

   assign awready         = wr_go;
   assign wready          = wr_go;
   assign arready         = rd_go;
   assign bvalid          = s.bvalid;
   assign bresp           = s.bresp;
   assign rvalid          = s.rvalid;
   assign rdata           = s.rdata;
   assign rresp           = s.rresp;
   assign pin_out         = s.pin_out;
   assign pin_oe          = s.pin_oe;
   assign outgoing_strobe = s.strobe_out;
   assign port_event      = s.event_out;

   ////////////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s    = s;
      wr_go     = awvalid & wvalid & ~s.bvalid;                              // RULE_04
      rd_go     = arvalid & ~s.rvalid;
      hw_set    = '0;
      port_tick = '0;
      live      = '0;
      mask      = '0;
      w         = '0;
      chunks    = '0;
      time_ok   = 1'b0;
      in_shift  = '0;
      img       = '0;
      owner     = '0;
      owned     = 1'b0;
      src_tick  = 1'b0;
      wp        = awaddr[7:5];
      rp        = araddr[7:5];
      wb        = awaddr[4:2];
      rb        = araddr[4:2];
      wmask     = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      next_s.strobe_out = '0;
      next_s.event_out  = '0;

      // clock blocks: block 0 is the fixed reference, others ref or pin sourced
      ref_tick          = (s.ref_cnt == 4'(REF_DIV - 1));                   // RULE_13
      next_s.ref_cnt    = ref_tick ? 4'h0 : s.ref_cnt + 4'h1;
      pin_edge          = pin_in[0] & ~s.pin0_prev;                          // RULE_14
      next_s.pin0_prev  = pin_in[0];
      blk_tick          = '0;
      blk_tick[0]       = ref_tick;
      for (int b = 1; b < NUM_CLKBLK; b++)
      begin
         src_tick = s.blk_src_pin[b] ? pin_edge : ref_tick;                  // RULE_14
         if (src_tick)
         begin
            if (s.blk_cnt[b] >= s.blk_div[b])                                // RULE_15
            begin
               blk_tick[b]       = 1'b1;
               next_s.blk_cnt[b] = '0;
            end
            else
               next_s.blk_cnt[b] = s.blk_cnt[b] + 8'h01;
         end
      end

      // per-port datapath
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         w       = PORT_WIDTH[p];                                            // RULE_01
         mask    = port_mask(w);
         chunks  = 6'(NUM_PINS / int'(w));
         live[p] = s.en[p] & ~(s.link_en & (|(mask & LINK_PIN_MASK)));      // RULE_10
         if (s.blk_sel[p] < 3'(NUM_CLKBLK))
            port_tick[p] = blk_tick[s.blk_sel[p]];                           // RULE_07
         time_ok = ~s.time_pend[p] | (s.count[p] == s.time_val[p]);        // RULE_08
         if (port_tick[p] && live[p])
         begin
            next_s.count[p] = s.count[p] + 16'h0001;                         // RULE_19
            if (s.dir_out[p])                                                // RULE_02
            begin
               if (s.shift_cnt[p] > 6'h01)
               begin
                  next_s.shift[p]      = s.shift[p] >> w;                    // RULE_06
                  next_s.shift_cnt[p]  = s.shift_cnt[p] - 6'h01;
                  next_s.strobe_out[p] = s.strb_en[p];                       // RULE_16
               end
               else if (s.xfer_full[p] && time_ok)                           // RULE_20
               begin
                  next_s.shift[p]      = s.xfer[p];
                  next_s.shift_cnt[p]  = chunks;
                  next_s.xfer_full[p]  = 1'b0;
                  next_s.time_pend[p]  = 1'b0;
                  next_s.stamp[p]      = s.count[p];                         // RULE_09
                  next_s.strobe_out[p] = s.strb_en[p];                       // RULE_16
               end
               else
                  next_s.shift_cnt[p]  = '0;
            end
            else if (s.cond_pend[p])
            begin
               if ((pin_in & mask) == (s.cond_val[p] & mask))                // RULE_03
               begin
                  next_s.xfer[p]      = pin_in & mask;
                  next_s.xfer_full[p] = 1'b1;
                  hw_set[p]           = 1'b1;
                  next_s.cond_pend[p] = 1'b0;                                // RULE_20
                  next_s.stamp[p]     = s.count[p];                          // RULE_09
                  next_s.event_out[p] = 1'b1;                                // RULE_18
               end
            end
            else if (time_ok && (~s.strb_en[p] || incoming_strobe[p]))       // RULE_16
            begin
               // full width sampled even where narrower ports own pins
               in_shift = (s.shift[p] >> w) | ((pin_in & mask) << (6'h20 - w)); // RULE_12
               next_s.shift[p] = in_shift;
               // the wait ends at the first sample, else a narrow port stalls mid-word
               next_s.time_pend[p] = 1'b0;                                   // RULE_20
               if (s.shift_cnt[p] + 6'h01 >= chunks)
               begin
                  next_s.shift_cnt[p] = '0;
                  next_s.xfer[p]      = in_shift;                            // RULE_06
                  next_s.xfer_full[p] = 1'b1;
                  hw_set[p]           = 1'b1;
                  next_s.stamp[p]     = s.count[p];                          // RULE_09
                  next_s.event_out[p] = 1'b1;                                // RULE_18
               end
               else
                  next_s.shift_cnt[p] = s.shift_cnt[p] + 6'h01;
            end
         end
      end

      // register writes; new output data written now outlives a same-cycle load
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (wr_go)
      begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         if (awaddr < PORT_END)
         begin
            unique case (awaddr[4:0])
               REG_CTRL:
               begin
                  img = {25'h0, s.blk_sel[wp], s.strb_en[wp], s.oc[wp], s.dir_out[wp], s.en[wp]};
                  img = (img & ~wmask) | (wdata & wmask);
                  next_s.en[wp]      = img[CTRL_EN];
                  next_s.dir_out[wp] = img[CTRL_DIR_OUT];
                  next_s.oc[wp]      = img[CTRL_OC];                         // RULE_05
                  next_s.strb_en[wp] = img[CTRL_STRB];
                  next_s.blk_sel[wp] = img[CTRL_BLK_LSB +: 3];
               end
               REG_DATA:
               begin
                  next_s.xfer[wp]      = (s.xfer[wp] & ~wmask) | (wdata & wmask);
                  next_s.xfer_full[wp] = 1'b1;
               end
               REG_TIME:
               begin
                  next_s.time_val[wp]  = wdata[COUNT_WIDTH-1:0];
                  next_s.time_pend[wp] = wdata[TIME_EN];                     // RULE_08
               end
               REG_COND:
               begin
                  next_s.cond_val[wp]  = wdata;
                  next_s.cond_pend[wp] = 1'b1;                               // RULE_03
               end
               REG_COUNT, REG_STAMP, REG_STATUS:
                  next_s.bresp = RESP_OKAY;
               default:
                  next_s.bresp = RESP_SLVERR;
            endcase
         end
         else if ((awaddr[11:5] == CLKBLK_BASE[11:5]) && (wb < 3'(NUM_CLKBLK)) && (wb != 3'h0))
         begin
            next_s.blk_src_pin[wb] = wdata[CLK_SRC_PIN];
            next_s.blk_div[wb]     = wdata[CLK_DIV_LSB +: DIV_WIDTH];
         end
         else if (awaddr == LINK_CTRL)
            next_s.link_en = wdata[0];
         else
            next_s.bresp = RESP_SLVERR;
      end

      // register reads; reading input data frees the transfer register unless a capture refills it in the same cycle
      if (s.rvalid && rready)
         next_s.rvalid = 1'b0;
      if (rd_go)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = '0;
         if (araddr < PORT_END)
         begin
            unique case (araddr[4:0])
               REG_CTRL:
                  next_s.rdata = {25'h0, s.blk_sel[rp], s.strb_en[rp], s.oc[rp],
                                  s.dir_out[rp], s.en[rp]};
               REG_DATA:
               begin
                  next_s.rdata = s.xfer[rp];
                  if (!s.dir_out[rp] && !hw_set[rp])
                  begin
                     next_s.xfer_full[rp] = 1'b0;
                  end
               end
               REG_COUNT:  next_s.rdata = {16'h0, s.count[rp]};              // RULE_08
               REG_STAMP:  next_s.rdata = {16'h0, s.stamp[rp]};              // RULE_09
               REG_TIME:   next_s.rdata = {15'h0, s.time_pend[rp], s.time_val[rp]};
               REG_COND:   next_s.rdata = s.cond_val[rp];
               REG_STATUS:
                  next_s.rdata = {27'h0, live[rp], s.time_pend[rp], s.cond_pend[rp],
                                  (s.shift_cnt[rp] != 6'h00), s.xfer_full[rp]};
               default:    next_s.rresp = RESP_SLVERR;
            endcase
         end
         else if ((araddr[11:5] == CLKBLK_BASE[11:5]) && (rb < 3'(NUM_CLKBLK)))
            next_s.rdata = {16'h0, s.blk_div[rb], 7'h00, s.blk_src_pin[rb]};
         else if (araddr == LINK_CTRL)
            next_s.rdata = {31'h0, s.link_en};
         else
            next_s.rresp = RESP_SLVERR;
      end

      // pin ownership: narrowest live port wins each pin
      for (int i = 0; i < NUM_PINS; i++)
      begin
         owned = 1'b0;
         owner = '0;
         for (int p = NUM_PORTS - 1; p >= 0; p--)
         begin
            mask = port_mask(PORT_WIDTH[p]);
            if (live[p] && mask[i])                                          // RULE_11
            begin
               owned = 1'b1;
               owner = 3'(p);
            end
         end
         next_s.pin_oe[i]  = 1'b0;
         next_s.pin_out[i] = 1'b0;
         if (owned && next_s.dir_out[owner])
         begin
            if (next_s.oc[owner])
               next_s.pin_oe[i] = ~next_s.shift[owner][i];                   // RULE_05
            else
            begin
               next_s.pin_oe[i]  = 1'b1;
               next_s.pin_out[i] = next_s.shift[owner][i];                   // RULE_03
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;                                                            // RULE_17
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
      wr_go |=> s.bvalid) else $error("write not answered next cycle");
   a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
      rd_go |=> s.rvalid) else $error("read not answered next cycle");
   a_ref_period: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_13
      blk_tick[0] |=> !blk_tick[0] ##1 blk_tick[0]) else $error("reference tick period wrong");
   a_reset_block: assert property (@(posedge aclk) // RULE_17
      !aresetn |=> (s.blk_sel == '0)) else $error("port not on block 0 after reset");
   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_19
      (port_tick[4] && live[4]) |=> s.count[4] == $past(s.count[4]) + 16'h0001)
      else $error("counter did not step on tick");
   a_link_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
      s.link_en |=> (s.pin_oe & LINK_PIN_MASK) == '0) else $error("port drives link pins");
   a_narrow_wins: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
      (live[0] && next_s.dir_out[0] && !next_s.oc[0]) |=> s.pin_out[0] == s.shift[0][0])
      else $error("pin 0 not from 1-bit port");
   a_stamp_event: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
      s.event_out[3] |-> s.stamp[3] == $past(s.count[3])) else $error("timestamp mismatch");

   c_pin_clock: cover property (@(posedge aclk) disable iff (!aresetn) blk_tick[1] && s.blk_src_pin[1]);
   c_input_word: cover property (@(posedge aclk) disable iff (!aresetn) s.event_out[3]);
   c_out_strobe: cover property (@(posedge aclk) disable iff (!aresetn) s.strobe_out[2]);

endmodule : clocked_io_port_unit

// ---- verif/pin_partner.sv ----
`timescale 1ns/1ps
module pin_partner
   import clocked_io_port_pkg::*;
(
   input  wire logic [NUM_PINS-1:0]  pin_out,
   input  wire logic [NUM_PINS-1:0]  pin_oe,
   input  wire logic [NUM_PINS-1:0]  ext_val,
   input  wire logic [NUM_PINS-1:0]  ext_en,
   input  wire logic [NUM_PORTS-1:0] strobe_req,
   output logic      [NUM_PINS-1:0]  pin_in,
   output logic      [NUM_PORTS-1:0] incoming_strobe
);
   // undriven pins fall to the pull-down level; a released open-collector pin reads low
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val);
   assign incoming_strobe = strobe_req;
endmodule : pin_partner

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import clocked_io_port_pkg::*;
;
   logic                  aclk = 1'b0, aresetn = 1'b0;
   logic [ADDR_WIDTH-1:0] awaddr = '0, araddr = '0;
   logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                  arvalid = 1'b0, rready = 1'b0;
   logic [31:0]           wdata = '0, rdata, lfsr = 32'h00016DCE, rd, word, c1;
   logic [3:0]            wstrb = 4'hF;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp, rs;
   logic [NUM_PINS-1:0]   pin_in, pin_out, pin_oe, m, ext_val = '0, ext_en = '0;
   logic [NUM_PORTS-1:0]  strobe_req = '0, incoming_strobe, outgoing_strobe, port_event;
   logic [31:0]           q[$];
   int                    failures = 0, n_compared = 0, cycles = 0, w;

   clocked_io_port_unit u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .incoming_strobe(incoming_strobe), .outgoing_strobe(outgoing_strobe),
      .port_event(port_event));
   pin_partner u_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .strobe_req(strobe_req), .pin_in(pin_in),
      .incoming_strobe(incoming_strobe));

   always #2.5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end
////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rs = bresp;
      bready  <= 1'b0;
   endtask : wr

   task automatic rdw(input logic [11:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready  <= 1'b0;
   endtask : rdw

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(pin_oe, 32'h00000000);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         rdw(12'(32 * p));
         chk(rd, 32'h00000000);
      end
      rdw(12'h008);
      chk(rd, 32'h00000000);
      rdw(12'h0A0);
      chk(32'(rs), 32'(RESP_SLVERR));
      $display("test reset done");
      // every width drives its word out lsb chunk first; port 2 as open collector
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         w = int'(PORT_WIDTH[p]);
         m = port_mask(PORT_WIDTH[p]);
         word = rnd();
         for (int k = 0; k < 32 / w; k++)
            q.push_back((word >> (k * w)) & m);
         wr(12'(32 * p), (p == 2) ? 32'h0000000F : 32'h0000000B);
         wr(12'(32 * p + 4), word);
         chk(32'(rs), 32'(RESP_OKAY));
         while (q.size() > 0)
         begin
            do @(posedge aclk); while (!outgoing_strobe[p]);
            if (p == 2)
               chk(pin_oe & m, ~q[0] & m);
            else
               chk(pin_in & m, q[0]);
            void'(q.pop_front());
         end
         wr(12'(32 * p), 32'h00000000);
         $display("test output port %0d done", p);
      end
      // input port 3 waits for the incoming strobe
      word = rnd();
      ext_val <= {2{word[15:0]}};
      ext_en  <= '1;
      wr(12'h060, 32'h00000009);
      repeat (20) @(posedge aclk);
      rdw(12'h078);
      chk(rd & 32'h00000001, 32'h00000000);
      strobe_req[3] <= 1'b1;
      do @(posedge aclk); while (!port_event[3]);
      rdw(12'h064);
      chk(rd, {2{word[15:0]}});
      rdw(12'h068);
      c1 = rd;
      rdw(12'h068);
      chk(rd, (c1 + 32'h00000001) & 32'h0000FFFF);
      $display("test input port done");
      // port 1 holds off until its pins match, then runs from pin 0 halved
      ext_val <= 32'h00000000;
      wr(12'h020, 32'h00000001);
      wr(12'h034, 32'h00000005);
      rdw(12'h038);
      chk(rd & 32'h00000004, 32'h00000004);
      ext_val <= 32'h00000005;
      do @(posedge aclk); while (!port_event[1]);
      rdw(12'h024);
      chk(rd, 32'h00000005);
      ext_val <= 32'h00000000;
      wr(12'h104, 32'h00000101);
      wr(12'h020, 32'h00000011);
      rdw(12'h028);
      c1 = rd;
      repeat (4)
      begin
         ext_val[0] <= 1'b1;
         repeat (2) @(posedge aclk);
         ext_val[0] <= 1'b0;
         repeat (2) @(posedge aclk);
      end
      rdw(12'h028);
      chk(rd, (c1 + 32'h00000002) & 32'h0000FFFF);
      $display("test pin clock done");
      wr(LINK_CTRL, 32'h00000001);
      rdw(12'h078);
      chk(rd & 32'h00000010, 32'h00000000);
      $display("test link done");
      results();
   end
endmodule : testbench
